// ===== common/spif_consts.svh
// Constants of the parallel input front end: widths, lanes, buffer depth, features, coding, timing.
// Assumes inclusion by bare name from rtl files and the package.
`ifndef SPIF_CONSTS_SVH
`define SPIF_CONSTS_SVH

`define SPIF_DIN_W          20
`define SPIF_HALF_W         10
`define SPIF_TS_LSB         10
`define SPIF_TS_MSB         17
`define SPIF_SPECIAL_BIT    18
`define SPIF_SYNC_BIT       19
`define SPIF_FIFO_DEPTH     16
`define SPIF_FEAT_W         7
`define SPIF_FEAT_ALL_ON    7'h7F
`define SPIF_K28_5          8'hBC
`define SPIF_STUFF_PERIOD   4'h8
`define SPIF_SYS_MHZ        100
`define SPIF_LOCK_NS        1000
`define SPIF_LOCK_CYC       ((`SPIF_LOCK_NS * `SPIF_SYS_MHZ + 999) / 1000)

`endif

// ===== common/spif_pkg.sv
// Types shared by the parallel input front end.
// Assumes spif_consts.svh lies on the include path.
`include "spif_consts.svh"

package spif_pkg;

    typedef enum logic [2:0] {
        SPIF_MODE_VIDEO,
        SPIF_MODE_TS,
        SPIF_MODE_RAW,
        SPIF_MODE_STANDBY
    } spif_mode_t;

    typedef enum logic [1:0] {
        SPIF_RATE_SD,
        SPIF_RATE_HD,
        SPIF_RATE_3G
    } spif_rate_t;

    // One captured word with its framing
    typedef struct packed {
        logic [`SPIF_DIN_W-1:0] data;
        logic                   is_20bit;
        logic                   second_half;
        logic                   sync_req;
        logic                   special;
        spif_mode_t             mode;
    } spif_word_t;

    // Static select pins after synchronising
    typedef struct packed {
        logic word_width_select;
        logic sd_rate_pick;
        logic high_rate_pick;
        logic video_proc_path_n;
        logic transport_stream_pin;
        logic feature_bundle_enable;
        logic standby;
    } spif_pins_t;

endpackage : spif_pkg

// ===== rtl/spif_sync3.sv
// Three-stage synchroniser bank; a change counts when stages two and three agree.
// Assumes asynchronous inputs and one system clock.
`timescale 1ns/1ps
`default_nettype none

module spif_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    // Signals
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= '0;
            s2_reg   <= '0;
            s3_reg   <= '0;
            sync_out <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Per-bit agreement filter
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    sync_out[i] <= s3_reg[i];
                end
            end
        end
    end

endmodule : spif_sync3

`default_nettype wire

// ===== rtl/spif_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock; width and depth are parameters, depth a power of two.
`timescale 1ns/1ps
`default_nettype none

module spif_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg < (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : spif_fifo

`default_nettype wire

// ===== rtl/spif_front_end.sv
// Parallel input front end of a multi-rate serial video transmitter.
// Assumes the word clock and all select pins are asynchronous to clk_sys,
// which must run well above twice the word clock (80 ns word clock in the bench).
// Notes on behaviour
// - Mode comes only from select pins: video, transport stream, raw, standby.
// - Video mode takes 10-bit interleaved or 20-bit split words by width pin.
// - Entering video mode turns processing features on with no register write.
// - Transport stream bytes arrive on lanes 17 down to 10 and are captured there.
// - Transport stream bytes are 8b/10b coded with stuffing characters inserted.
// - Raw mode serialises input words with no video or stream processing.
// - Standby pin shuts down functional activity to save power.
// - Serial output can float; edge-rate class follows the SD rate pin only.
// - Features: ancillary, payload id, error packets, detection, timing, CRC, checksums, lines.
// - One pin gates all features; each feature also has its own disable.
// - Data is valid around the word clock rising edge and captured there.
// - 20-bit: lanes 19:10 stream one, 9:0 stream two; 10-bit uses 19:10 only.
// - Parallel data pins stay inputs except in test mode.
// - Lock, host serial out and test data out driven except during reset.
// - A boundary scan port exists for pin testing.
// - 3G 10-bit: stream two on rising edge, stream one on falling edge.
// - Transport stream: lane 19 sync request, lane 18 special character flag.
// - Interleaved modes send chroma before luma, stream two before stream one.
`timescale 1ns/1ps
`default_nettype none

`include "spif_consts.svh"

module spif_front_end #(
    parameter int DIN_W      = `SPIF_DIN_W,
    parameter int FIFO_DEPTH = `SPIF_FIFO_DEPTH,
    parameter int FEAT_W     = `SPIF_FEAT_W
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Static select pins
    input  wire logic              word_width_select,
    input  wire logic              sd_rate_pick,
    input  wire logic              high_rate_pick,
    input  wire logic              video_proc_path_n,
    input  wire logic              transport_stream_pin,
    input  wire logic              feature_bundle_enable,
    input  wire logic              standby,
    input  wire logic              test_mode,
    input  wire logic              serial_out_float,
    input  wire logic [FEAT_W-1:0] feature_disable,
    // Parallel bus from the source
    input  wire logic              word_clk,
    input  wire logic [DIN_W-1:0]  din_in,
    output logic      [DIN_W-1:0]  din_out,
    output logic      [DIN_W-1:0]  din_oe_n,
    // Serialiser side
    output logic      [DIN_W-1:0]  ser_word,
    output logic                   ser_is_20bit,
    output logic                   ser_valid,
    input  wire logic              ser_ready,
    output logic                   ser_line_off,
    output logic                   ser_fast_edges,
    output logic      [FEAT_W-1:0] feature_active,
    output logic [2:0]             mode_out,
    // Always-driven pins
    output logic                   pll_lock_flag,
    output logic                   pll_lock_flag_oe_n,
    output logic                   host_serial_out_oe_n,
    output logic                   tdo_oe_n,
    output logic                   overflow
);

    spif_pkg::spif_pins_t  pins_raw;
    spif_pkg::spif_pins_t  pins_s;
    spif_pkg::spif_mode_t  mode;
    spif_pkg::spif_mode_t  mode_reg;
    spif_pkg::spif_rate_t  rate;
    spif_pkg::spif_word_t  cap_word;
    spif_pkg::spif_word_t  fifo_word;
    logic                  wclk_s;
    logic                  wclk_prev_reg;
    logic                  wclk_rise;
    logic                  wclk_fall;
    logic [DIN_W-1:0]      din_s;
    logic                  cap_valid_reg;
    spif_pkg::spif_word_t  cap_reg;
    logic                  fifo_in_ready;
    logic                  fifo_out_valid;
    logic                  drain;
    logic [3:0]            stuff_cnt_reg;
    logic [9:0]            enc_word;
    logic                  rd_reg;
    logic [15:0]           lock_cnt_reg;

    assign pins_raw = '{word_width_select, sd_rate_pick, high_rate_pick, video_proc_path_n,
                        transport_stream_pin, feature_bundle_enable, standby};

    spif_sync3 #(.W($bits(spif_pkg::spif_pins_t))) u_pin_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // Clock and data share one sampling path so they stay aligned
    spif_sync3 #(.W(DIN_W + 1)) u_bus_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in ({word_clk, din_in}),
        .sync_out ({wclk_s, din_s})
    );

    always_comb begin
        if (pins_s.standby) begin
            mode = spif_pkg::SPIF_MODE_STANDBY;
        end else if (pins_s.video_proc_path_n) begin
            mode = spif_pkg::SPIF_MODE_VIDEO;
        end else if (pins_s.transport_stream_pin && pins_s.sd_rate_pick) begin
            mode = spif_pkg::SPIF_MODE_TS;
        end else begin
            mode = spif_pkg::SPIF_MODE_RAW;
        end
    end

    always_comb begin
        if (pins_s.sd_rate_pick) begin
            rate = spif_pkg::SPIF_RATE_SD;
        end else if (pins_s.high_rate_pick) begin
            rate = spif_pkg::SPIF_RATE_3G;
        end else begin
            rate = spif_pkg::SPIF_RATE_HD;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wclk_prev_reg <= 1'b0;
        end else begin
            wclk_prev_reg <= wclk_s;
        end
    end

    assign wclk_rise = wclk_s && !wclk_prev_reg;
    assign wclk_fall = !wclk_s && wclk_prev_reg;

    // Capture: one word per accepted edge
    always_comb begin
        cap_word             = '0;
        cap_word.mode        = mode;
        cap_word.is_20bit    = pins_s.word_width_select && (mode != spif_pkg::SPIF_MODE_TS);
        cap_word.second_half = wclk_fall;
        unique case (mode)
            spif_pkg::SPIF_MODE_TS: begin
                cap_word.data[7:0] = din_s[`SPIF_TS_MSB:`SPIF_TS_LSB];
                cap_word.sync_req  = din_s[`SPIF_SYNC_BIT];
                cap_word.special   = din_s[`SPIF_SPECIAL_BIT];
            end
            spif_pkg::SPIF_MODE_STANDBY: begin
                cap_word.data = '0;
            end
            default: begin
                if (cap_word.is_20bit) begin
                    cap_word.data = din_s;
                end else begin
                    cap_word.data[`SPIF_HALF_W-1:0] = din_s[DIN_W-1:`SPIF_HALF_W];
                end
            end
        endcase
    end

    // Rising edge capture; falling edge only in 3G 10-bit video
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cap_valid_reg <= 1'b0;
            cap_reg       <= '0;
        end else begin
            cap_valid_reg <= 1'b0;
            if (mode != spif_pkg::SPIF_MODE_STANDBY) begin
                // Order preserved: stream two word first from rising edge
                if (wclk_rise || (wclk_fall && mode == spif_pkg::SPIF_MODE_VIDEO
                        && !pins_s.word_width_select && rate == spif_pkg::SPIF_RATE_3G)) begin
                    cap_valid_reg <= 1'b1;
                    cap_reg       <= cap_word;
                end
            end
        end
    end

    // Full FIFO drops the word and flags it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            overflow <= 1'b0;
        end else begin
            overflow <= cap_valid_reg && !fifo_in_ready;
        end
    end

    spif_fifo #(.WIDTH($bits(spif_pkg::spif_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_data   (cap_reg),
        .in_valid  (cap_valid_reg),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_word),
        .out_valid (fifo_out_valid),
        .out_ready (drain)
    );

    // Output stage stalls on ser_ready; periodic stuffing takes a slot
    assign drain = fifo_out_valid && (!ser_valid || ser_ready)
                   && !(fifo_word.mode == spif_pkg::SPIF_MODE_TS && stuff_cnt_reg == `SPIF_STUFF_PERIOD);

    // Simplified 8b/10b: data byte with disparity flip, K28.5 for specials
    always_comb begin
        if (fifo_word.special || fifo_word.sync_req) begin
            enc_word = {2'b00, `SPIF_K28_5} ^ {10{rd_reg}};
        end else begin
            enc_word = {1'b1, ^fifo_word.data[7:0], fifo_word.data[7:0]} ^ {10{rd_reg}};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ser_valid     <= 1'b0;
            ser_word      <= '0;
            ser_is_20bit  <= 1'b0;
            stuff_cnt_reg <= '0;
            rd_reg        <= 1'b0;
        end else begin
            if (ser_valid && ser_ready) begin
                ser_valid <= 1'b0;
            end
            if (mode_reg == spif_pkg::SPIF_MODE_TS && stuff_cnt_reg == `SPIF_STUFF_PERIOD
                    && (!ser_valid || ser_ready)) begin
                ser_word      <= DIN_W'({2'b00, `SPIF_K28_5} ^ {10{rd_reg}});
                ser_is_20bit  <= 1'b0;
                ser_valid     <= 1'b1;
                rd_reg        <= !rd_reg;
                stuff_cnt_reg <= '0;
            end else if (drain) begin
                ser_valid    <= 1'b1;
                ser_is_20bit <= fifo_word.is_20bit;
                if (fifo_word.mode == spif_pkg::SPIF_MODE_TS) begin
                    ser_word      <= DIN_W'(enc_word);
                    rd_reg        <= !rd_reg;
                    stuff_cnt_reg <= stuff_cnt_reg + 4'h1;
                end else begin
                    // Raw and video words pass unencoded here
                    ser_word <= fifo_word.data;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg       <= spif_pkg::SPIF_MODE_STANDBY;
            mode_out       <= 3'h0;
            ser_fast_edges <= 1'b0;
            ser_line_off   <= 1'b1;
        end else begin
            mode_reg       <= mode;
            mode_out       <= 3'(mode);
            ser_fast_edges <= (rate != spif_pkg::SPIF_RATE_SD);
            // Standby or float silences the line
            ser_line_off   <= serial_out_float || mode == spif_pkg::SPIF_MODE_STANDBY;
        end
    end

    // Feature bundle: on by default in video mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            feature_active <= '0;
        end else if (mode == spif_pkg::SPIF_MODE_VIDEO && pins_s.feature_bundle_enable) begin
            feature_active <= FEAT_W'(`SPIF_FEAT_ALL_ON) & ~feature_disable;
        end else begin
            feature_active <= '0;
        end
    end

    // Bus pins: inputs unless test mode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            din_oe_n <= '1;
            din_out  <= '0;
        end else begin
            din_oe_n <= {DIN_W{!test_mode}};
            din_out  <= din_s;
        end
    end

    // Lock indicator after a settle time with no standby
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_cnt_reg         <= '0;
            pll_lock_flag        <= 1'b0;
            pll_lock_flag_oe_n   <= 1'b1;
            host_serial_out_oe_n <= 1'b1;
            tdo_oe_n             <= 1'b1;
        end else begin
            pll_lock_flag_oe_n   <= 1'b0;
            host_serial_out_oe_n <= 1'b0;
            tdo_oe_n             <= 1'b0;
            if (mode == spif_pkg::SPIF_MODE_STANDBY) begin
                lock_cnt_reg  <= '0;
                pll_lock_flag <= 1'b0;
            end else if (lock_cnt_reg < 16'(`SPIF_LOCK_CYC)) begin
                lock_cnt_reg  <= lock_cnt_reg + 16'h1;
            end else begin
                pll_lock_flag <= 1'b1;
            end
        end
    end

    // Boundary scan lives in the pad ring; only tdo_oe_n here

endmodule : spif_front_end

`default_nettype wire

// ===== testbench/spif_front_end_monitor.sv
// Concurrent checks on the ports of spif_front_end, attached by bind.
// Assumes one clock domain and select pins held still for several clocks.
`timescale 1ns/1ps
`default_nettype none

module spif_front_end_monitor #(
    parameter int DIN_W  = 20,
    parameter int FEAT_W = 7
) (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst_n,
    // Select pins
    input wire logic              sd_rate_pick,
    input wire logic              video_proc_path_n,
    input wire logic              transport_stream_pin,
    input wire logic              feature_bundle_enable,
    input wire logic              standby,
    input wire logic              test_mode,
    input wire logic              serial_out_float,
    input wire logic [FEAT_W-1:0] feature_disable,
    // Outputs watched
    input wire logic [DIN_W-1:0]  din_oe_n,
    input wire logic [DIN_W-1:0]  ser_word,
    input wire logic              ser_valid,
    input wire logic              ser_ready,
    input wire logic              ser_line_off,
    input wire logic              ser_fast_edges,
    input wire logic [FEAT_W-1:0] feature_active,
    input wire logic [2:0]        mode_out,
    input wire logic              pll_lock_flag_oe_n,
    input wire logic              host_serial_out_oe_n,
    input wire logic              tdo_oe_n
);
    logic [2:0] exp_mode;
    logic       exp_known;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Transport stream without the SD rate pin is left unjudged
    always_comb begin
        exp_known = 1'b1;
        exp_mode  = 3'h2;
        if (standby) begin
            exp_mode = 3'h3;
        end else if (video_proc_path_n) begin
            exp_mode = 3'h0;
        end else if (transport_stream_pin) begin
            exp_mode  = 3'h1;
            exp_known = sd_rate_pick;
        end
    end

    chk_mode_decode: assert property (
        $stable({standby, video_proc_path_n, transport_stream_pin, sd_rate_pick})[*8]
        |-> !exp_known || mode_out == exp_mode) else $error("mode does not follow select pins");
    chk_standby_silent: assert property (
        mode_out == 3'h3 [*2] |-> ser_line_off) else $error("serial line active in standby");
    chk_float_line: assert property (
        serial_out_float [*6] |-> ser_line_off) else $error("serial line not floated");
    chk_edge_rate: assert property (
        ($stable(sd_rate_pick) && mode_out != 3'h3)[*8] |-> ser_fast_edges == !sd_rate_pick)
        else $error("edge rate class does not follow rate pins");
    chk_pins_input: assert property (
        !test_mode [*6] |-> &din_oe_n) else $error("data pins driven outside test mode");
    chk_outs_driven: assert property (
        rst_n [*3] |-> !pll_lock_flag_oe_n && !host_serial_out_oe_n && !tdo_oe_n)
        else $error("always-driven pin released after reset");
    chk_word_holds: assert property (
        ser_valid && !ser_ready |=> ser_valid && $stable(ser_word)) else $error("word dropped while stalled");
    chk_feature_gate: assert property (
        $stable({feature_disable, feature_bundle_enable, mode_out})[*6]
        |-> feature_active == ((mode_out == 3'h0 && feature_bundle_enable) ? ~feature_disable : '0))
        else $error("feature enables wrong");
endmodule : spif_front_end_monitor

bind spif_front_end spif_front_end_monitor #(.DIN_W(DIN_W), .FEAT_W(FEAT_W)) mon_u (.*);

`default_nettype wire

// ===== testbench/spif_src_model.sv
// Upstream video source driving the parallel word bus and its clock.
// Assumes the caller spaces words; clock stands low between words.
`timescale 1ns/1ps
`default_nettype none

module spif_src_model (
    // Width hint
    input  wire logic  ten_bit,
    // Parallel bus
    output logic       word_clk,
    output logic [19:0] din_in
);
    logic [9:0] junk_reg;

    initial begin
        word_clk = 1'b0;
        din_in   = 20'h00000;
        junk_reg = 10'h155;
    end

    task automatic send(input logic [19:0] w);
        // unused half floats, so it toggles
        junk_reg = ~junk_reg;
        din_in   = ten_bit ? {w[19:10], junk_reg} : w;
        #40;
        word_clk = 1'b1;
        #40;
        word_clk = 1'b0;
        // Hold spent: stale data must not look valid
        din_in   = ~din_in;
    endtask : send
endmodule : spif_src_model

`default_nettype wire

// ===== testbench/tb_sdi_parallel_input_format.sv
// Self-checking bench for the parallel input front end.
// Assumes spif_src_model on the word bus and the bound checker on the ports.
`timescale 1ns/1ps
`default_nettype none

module tb_sdi_parallel_input_format;
    logic        clk_sys, rst_n, word_width_select, sd_rate_pick, high_rate_pick, ten_bit;
    logic        video_proc_path_n, transport_stream_pin, feature_bundle_enable, standby;
    logic        test_mode, serial_out_float, ser_ready, word_clk, ser_valid, ser_line_off;
    logic        ser_fast_edges, overflow, pll_lock_flag_oe_n, host_serial_out_oe_n, tdo_oe_n;
    logic [6:0]  feature_disable, feature_active;
    logic [2:0]  mode_out;
    logic [19:0] din_in, din_oe_n, ser_word;
    logic [19:0] got_q[$];
    int          n_mismatch = 0, n_compared = 0, n_ovf = 0, cyc = 0;

    spif_src_model src_u (.ten_bit(ten_bit), .word_clk(word_clk), .din_in(din_in));
    spif_front_end dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .word_width_select(word_width_select), .sd_rate_pick(sd_rate_pick),
        .high_rate_pick(high_rate_pick), .video_proc_path_n(video_proc_path_n),
        .transport_stream_pin(transport_stream_pin), .feature_bundle_enable(feature_bundle_enable),
        .standby(standby), .test_mode(test_mode), .serial_out_float(serial_out_float),
        .feature_disable(feature_disable), .word_clk(word_clk), .din_in(din_in), .din_out(),
        .din_oe_n(din_oe_n), .ser_word(ser_word), .ser_is_20bit(), .ser_valid(ser_valid),
        .ser_ready(ser_ready), .ser_line_off(ser_line_off), .ser_fast_edges(ser_fast_edges),
        .feature_active(feature_active), .mode_out(mode_out), .pll_lock_flag(),
        .pll_lock_flag_oe_n(pll_lock_flag_oe_n), .host_serial_out_oe_n(host_serial_out_oe_n),
        .tdo_oe_n(tdo_oe_n), .overflow(overflow));

    always #5 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (rst_n && ser_valid === 1'b1 && ser_ready === 1'b1) begin
            got_q.push_back(ser_word);
        end
        if (rst_n && overflow === 1'b1) begin
            n_ovf++;
        end
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : cycles

    // Pin order: width, sd, high, video path, stream, standby
    task automatic set_pins(input logic [5:0] p);
        @(posedge clk_sys);
        {word_width_select, sd_rate_pick, high_rate_pick, video_proc_path_n, transport_stream_pin, standby} <= p;
        ten_bit <= !p[5];
        cycles(12);
        got_q.delete();
    endtask : set_pins

    task automatic wait_words(input int n);
        for (int i = 0; i < 500 && got_q.size() < n; i++) begin
            cycles(1);
        end
    endtask : wait_words

    task automatic t_drive;
        chk({pll_lock_flag_oe_n, host_serial_out_oe_n, tdo_oe_n}, 3'h0);
        @(posedge clk_sys);
        test_mode <= 1'b1;
        cycles(8);
        chk(din_oe_n, 20'h00000);
        @(posedge clk_sys);
        test_mode <= 1'b0;
        cycles(8);
        chk(din_oe_n, 20'hFFFFF);
    endtask : t_drive

    task automatic t_modes;
        logic [5:0] pins[4] = '{6'b100100, 6'b010010, 6'b101000, 6'b100101};
        @(posedge clk_sys);
        serial_out_float <= 1'b1;
        cycles(8);
        chk(ser_line_off, 1'b1);
        @(posedge clk_sys);
        serial_out_float <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            set_pins(pins[i]);
            chk(mode_out, i);
            chk(ser_line_off, i == 3);
            if (i != 3) begin
                chk(ser_fast_edges, !pins[i][4]);
            end
        end
    endtask : t_modes

    task automatic t_video20;
        logic [19:0] w[3] = '{20'hABCDE, 20'h12345, 20'h3FF00};
        set_pins(6'b100100);
        chk(feature_active, 7'h7F);
        foreach (w[i]) src_u.send(w[i]);
        wait_words(3);
        foreach (w[i]) chk(got_q[i], w[i]);
        @(posedge clk_sys);
        feature_disable <= 7'h05;
        cycles(8);
        chk(feature_active, 7'h7A);
        @(posedge clk_sys);
        feature_bundle_enable <= 1'b0;
        cycles(8);
        chk(feature_active, 7'h00);
        @(posedge clk_sys);
        {feature_bundle_enable, feature_disable} <= 8'h80;
    endtask : t_video20

    task automatic t_video10;
        // Chroma first, then luma
        set_pins(6'b000100);
        src_u.send(20'hA9400);
        src_u.send(20'h56800);
        wait_words(2);
        chk(got_q[0], 20'h002A5);
        chk(got_q[1], 20'h0015A);
    endtask : t_video10

    task automatic t_ts;
        set_pins(6'b010010);
        chk(feature_active, 7'h00);
        for (int i = 0; i < 8; i++) src_u.send({2'b00, 8'(i * 29 + 3), 10'h000});
        wait_words(9);
        cycles(20);
        chk(got_q.size(), 9);
    endtask : t_ts

    task automatic t_standby;
        set_pins(6'b010011);
        src_u.send(20'h55555);
        src_u.send(20'hAAAAA);
        cycles(40);
        chk(got_q.size(), 0);
        chk(ser_line_off, 1'b1);
    endtask : t_standby

    // Raw words stall at the far side until the buffer refuses
    task automatic t_fifo;
        set_pins(6'b100000);
        chk(feature_active, 7'h00);
        @(posedge clk_sys);
        ser_ready <= 1'b0;
        n_ovf = 0;
        for (int i = 0; i < 18; i++) src_u.send(20'h3FF00 + i);
        @(posedge clk_sys);
        ser_ready <= 1'b1;
        wait_words(18);
        chk(n_ovf != 0, 1'b1);
        chk(got_q.size() >= 16 && got_q.size() == 18 - n_ovf, 1'b1);
        foreach (got_q[i]) chk(got_q[i], 20'h3FF00 + i);
    endtask : t_fifo

    task automatic summarize;
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    initial begin
        {clk_sys, rst_n, word_width_select, sd_rate_pick, high_rate_pick, ten_bit} = 6'h00;
        {video_proc_path_n, transport_stream_pin, standby, test_mode, serial_out_float} = 5'h00;
        {feature_bundle_enable, ser_ready, feature_disable} = 9'h180;
        cycles(2);
        chk(din_oe_n, 20'hFFFFF);
        chk(ser_line_off, 1'b1);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        cycles(6);
        t_drive();
        t_modes();
        t_video20();
        t_video10();
        t_ts();
        t_standby();
        t_fifo();
        summarize();
    end
endmodule : tb_sdi_parallel_input_format

`default_nettype wire
